// ---- logic/uart_ctl_regs.svh ----
`ifndef UART_CTL_REGS_SVH
`define UART_CTL_REGS_SVH

// register indices; byte address is four times the index
`define IDX_STATUS      15'h4100
`define IDX_TX_DATA     15'h4101
`define IDX_RX_DATA     15'h4102
`define IDX_MODE        15'h4103
`define IDX_CONTROL     15'h4104
`define IDX_EXPANSION   15'h4105
`define IDX_BAUD        15'h4106
`define IDX_FINE        15'h4107
`define IDX_IRQ_STATUS  15'h4108
`define IDX_CLOCK_CTL   15'h506c

// control register fields; interrupt status uses the same bit layout
`define CTL_TX_DONE_IE  7
`define CTL_RX_ERR_IE   6
`define CTL_RX_FULL_IE  5
`define CTL_TX_EMPTY_IE 4
`define CTL_THRESHOLD   1
`define CTL_ENABLE      0

// status register fields
`define ST_TX_DONE      7
`define ST_FRAME_ERR    6
`define ST_PARITY_ERR   5
`define ST_OVERRUN      4
`define ST_SECOND_BYTE  3
`define ST_TX_BUSY      2
`define ST_RX_READY     1
`define ST_TX_EMPTY     0

// clock control fields
`define CLK_DIV_MSB     5
`define CLK_DIV_LSB     4
`define CLK_SRC_MSB     3
`define CLK_SRC_LSB     2
`define CLK_GATE        0

// reset values and receive buffer depth
`define RST_BYTE        8'h00
`define RST_TX_EMPTY    1'b1
`define RX_DEPTH        2'h2

`endif

// ---- logic/uart_ctl_pkg.sv ----
package uart_ctl_pkg;

   // count clock source codes, in register order
   typedef enum logic [1:0] {SRC_INTERNAL, SRC_LOW_SPEED, SRC_HIGH_SPEED, SRC_EXTERNAL} clk_src_e;

   typedef logic [7:0] byte_t;

   // sticky flag update: a set in the same cycle as a clear wins
   function automatic byte_t w1c(input byte_t cur, input byte_t set, input byte_t clr);
      w1c = (cur & ~clr) | set;
   endfunction : w1c

   // low bits that must be all ones to pass 1/1, 1/2, 1/4, 1/8
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      div_mask = (code == 2'h0) ? 3'h0 : (code == 2'h1) ? 3'h1 : (code == 2'h2) ? 3'h3 : 3'h7;
   endfunction : div_mask

endpackage : uart_ctl_pkg

// ---- logic/count_clock_gen.sv ----
`timescale 1ns/1ps
`include "uart_ctl_regs.svh"

module count_clock_gen
(
   // clock and synchronised reset
   input  wire logic       core_clk,
   input  wire logic       rst_sync_b,
   // oscillator pins: internal, low speed, high speed, external
   input  wire logic [3:0] osc_pins,
   // configuration
   input  wire logic [1:0] clk_source,
   input  wire logic [1:0] clk_divide,
   input  wire logic       clk_gate,
   input  wire logic       run,
   input  wire logic [7:0] baud_divisor,
   input  wire logic [3:0] fine_delay_count,
   // one-cycle pulse per baud counter underflow
   output logic            baud_tick
);

   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [3:0] sync3_r;
   logic [2:0] div_cnt_r;
   logic [7:0] cnt_r;
   logic [3:0] uf_cnt_r;
   logic       stretch_r;
   logic       baud_tick_r;

   // pins are foreign clocks: two flops, then a third for edge detection
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         sync3_r <= 4'h0;
      end
      else
      begin
         sync1_r <= osc_pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end

   // source select and divider; oscillators must run below core_clk/2
   wire [3:0] rise_w     = sync2_r & ~sync3_r;
   wire       sel_edge   = rise_w[clk_source];
   wire       div_apply  = (clk_source == uart_ctl_pkg::SRC_INTERNAL) ||
                           (clk_source == uart_ctl_pkg::SRC_HIGH_SPEED);
   wire [2:0] mask_w     = uart_ctl_pkg::div_mask(clk_divide);
   wire       div_hit    = !div_apply || ((div_cnt_r & mask_w) == mask_w);
   wire       count_en   = clk_gate && sel_edge && div_hit;
   wire       delay_due  = uf_cnt_r < fine_delay_count;
   wire       at_zero    = cnt_r == 8'h00;

   // divider counts source edges; it restarts while the gate is off
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
         div_cnt_r <= 3'h0;
      else if (!clk_gate)
         div_cnt_r <= 3'h0;
      else if (sel_edge)
         div_cnt_r <= div_cnt_r + 3'h1;

   // baud counter with one stretched cycle per due underflow in sixteen
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         cnt_r       <= 8'h00;
         uf_cnt_r    <= 4'h0;
         stretch_r   <= 1'b0;
         baud_tick_r <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r       <= baud_divisor;
         uf_cnt_r    <= 4'h0;
         stretch_r   <= 1'b0;
         baud_tick_r <= 1'b0;
      end
      else
      begin
         baud_tick_r <= 1'b0;
         if (count_en && at_zero && delay_due && !stretch_r)
            stretch_r <= 1'b1;
         else if (count_en && at_zero)
         begin
            baud_tick_r <= 1'b1;
            cnt_r       <= baud_divisor;
            uf_cnt_r    <= uf_cnt_r + 4'h1;
            stretch_r   <= 1'b0;
         end
         else if (count_en)
            cnt_r <= cnt_r - 8'h01;
      end

   assign baud_tick = baud_tick_r;

   a_fine_stretch: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (run && count_en && at_zero && delay_due && !stretch_r) |=> (!baud_tick && stretch_r))
      else $error("due underflow was not stretched");

   a_fine_plain: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (run && count_en && at_zero && !delay_due) |=> baud_tick && (cnt_r == $past(baud_divisor)))
      else $error("underflow without delay missed its tick");

   a_div_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (!clk_gate || (div_apply && clk_divide == 2'h3 && div_cnt_r[2:0] != 3'h7)) |-> !count_en)
      else $error("count clock passed while gated or divided");

endmodule : count_clock_gen

// ---- logic/uart_control_baud_clock.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "uart_ctl_regs.svh"

// How it works
// - control bit 7 set lets the transmission-complete interrupt through, clear blocks it.
// - control bit 6 set lets the receive-error interrupt through, clear blocks it.
// - control bit 5 set lets the receive-buffer-full interrupt through, clear blocks it.
// - control bit 4 set lets the transmit-buffer-empty interrupt through, clear blocks it.
// - control bit 1 picks a full threshold of two buffered bytes when set, one when clear.
// - the fine field says how many underflows in every sixteen get one extra cycle.
// - the divide field passes 1/1, 1/2, 1/4 or 1/8 of the internal or high-speed source.
// - the transmission-complete status flag is set by hardware, cleared by writing one.
// - a status flag shows that a second received byte sits in the buffer.
// - a read-only status flag, one after reset, shows the transmit buffer is empty.
module uart_control_baud_clock
#(
   parameter int ADDR_W = 17
)
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // count clock pins
   input  wire logic              internal_oscillator,
   input  wire logic              low_speed_oscillator,
   input  wire logic              high_speed_oscillator,
   input  wire logic              ext_clock,
   // transmit side of the shift logic
   output logic [7:0]             tx_byte,
   output logic                   tx_byte_valid,
   input  wire logic              tx_byte_ready,
   input  wire logic              tx_busy,
   input  wire logic              tx_done_evt,
   // receive side of the shift logic
   input  wire logic [7:0]        rx_byte,
   input  wire logic              rx_byte_valid,
   input  wire logic              rx_frame_err,
   input  wire logic              rx_parity_err,
   // configuration to the shift logic
   output logic                   port_enable,
   output logic                   infrared_mode,
   output logic                   char_len_8,
   output logic                   parity_en,
   output logic                   parity_odd,
   output logic                   stop_bits_2,
   output logic                   baud_tick,
   // interrupt
   output logic                   irq
);

   logic       rst_m_r;
   logic       rst_sync_b;
   logic [7:0] ctl_r;
   logic [7:0] exp_r;
   logic [7:0] baud_r;
   logic [3:0] fine_r;
   logic [7:0] clk_ctl_r;
   logic [7:0] mode_r;
   logic [7:0] flags_r;
   logic [7:0] irq_st_r;
   logic [7:0] tx_buf_r;
   logic       tx_buffer_empty_flag_r;
   logic [7:0] rx_mem_r [2];
   logic [1:0] rx_cnt_r;
   logic       full_lvl_r;
   logic [31:0] prdata_r;

   // reset is released through two flops so every flop on rst_sync_b leaves reset together
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         rst_m_r    <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_m_r    <= 1'b1;
         rst_sync_b <= rst_m_r;
      end

   // address decode; printed offsets are word indices
   wire [14:0] idx_w       = paddr[16:2];
   wire        aligned     = paddr[1:0] == 2'h0;
   wire        hit_status  = idx_w == `IDX_STATUS;
   wire        hit_tx      = idx_w == `IDX_TX_DATA;
   wire        hit_rx      = idx_w == `IDX_RX_DATA;
   wire        hit_mode    = idx_w == `IDX_MODE;
   wire        hit_ctl     = idx_w == `IDX_CONTROL;
   wire        hit_exp     = idx_w == `IDX_EXPANSION;
   wire        hit_baud    = idx_w == `IDX_BAUD;
   wire        hit_fine    = idx_w == `IDX_FINE;
   wire        hit_irq     = idx_w == `IDX_IRQ_STATUS;
   wire        hit_clk     = idx_w == `IDX_CLOCK_CTL;
   wire        mapped      = aligned && (hit_status || hit_tx || hit_rx || hit_mode ||
                             hit_ctl || hit_exp || hit_baud || hit_fine || hit_irq || hit_clk);
   wire        access      = psel && penable;
   wire        wr_acc      = access && pwrite && mapped;
   wire        rd_acc      = access && !pwrite && mapped;
   wire        rd_setup    = psel && !penable && !pwrite;
   wire [7:0]  wbyte       = pwdata[7:0];

   // zero wait state; unmapped or misaligned access answers with an error
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // receive buffer: two bytes, oldest read first, overrun drops the new byte
   wire        rx_take     = rx_byte_valid && port_enable;
   wire        rx_pop      = rd_acc && hit_rx && (rx_cnt_r != 2'h0);
   wire        rx_push     = rx_take && ((rx_cnt_r != `RX_DEPTH) || rx_pop);
   wire        rx_overrun  = rx_take && (rx_cnt_r == `RX_DEPTH) && !rx_pop;
   wire [1:0]  rx_slot     = rx_cnt_r - {1'b0, rx_pop};
   wire [1:0]  rx_cnt_nxt  = rx_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
   wire        second_byte = rx_cnt_r == `RX_DEPTH;
   wire        rx_ready    = rx_cnt_r != 2'h0;
   wire        full_nxt    = ctl_r[`CTL_THRESHOLD] ? (rx_cnt_nxt == `RX_DEPTH)
                                                   : (rx_cnt_nxt != 2'h0);

   // transmit buffer handshake; a byte is offered only while the port runs
   wire        tx_taken    = tx_byte_valid && tx_byte_ready;
   wire        tx_write    = wr_acc && hit_tx;
   assign tx_byte_valid = !tx_buffer_empty_flag_r && port_enable;
   assign tx_byte       = tx_buf_r;

   // hardware events and software clears of the flag registers
   wire [7:0]  flag_set    = {tx_done_evt, rx_take && rx_frame_err, rx_take && rx_parity_err,
                              rx_overrun, 4'h0};
   wire [7:0]  flag_clr    = (wr_acc && hit_status) ? (wbyte & 8'hf0) : 8'h00;
   wire        rx_err_evt  = |flag_set[6:4];
   wire        empty_evt   = tx_taken && !tx_write;
   wire [7:0]  irq_set     = {tx_done_evt, rx_err_evt, full_nxt && !full_lvl_r, empty_evt, 4'h0};
   wire [7:0]  irq_clr     = (wr_acc && hit_irq) ? (wbyte & 8'hf0) : 8'h00;

   // status read view; tx_buffer_empty_flag and the buffer levels are read only
   wire [7:0]  status_w    = {flags_r[7:4], second_byte, tx_busy, rx_ready, tx_buffer_empty_flag_r};

   // read data multiplexer; reserved bits read zero
   wire [7:0]  rd_byte     = hit_status ? status_w :
                             hit_tx     ? tx_buf_r :
                             hit_rx     ? rx_mem_r[0] :
                             hit_mode   ? (mode_r & 8'h1e) :
                             hit_ctl    ? (ctl_r & 8'hf3) :
                             hit_exp    ? (exp_r & 8'h01) :
                             hit_baud   ? baud_r :
                             hit_fine   ? {4'h0, fine_r} :
                             hit_irq    ? irq_st_r :
                             hit_clk    ? (clk_ctl_r & 8'h3d) : 8'h00;

   // configuration registers written by software
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         ctl_r     <= `RST_BYTE;
         exp_r     <= `RST_BYTE;
         baud_r    <= `RST_BYTE;
         fine_r    <= 4'h0;
         clk_ctl_r <= `RST_BYTE;
         mode_r    <= `RST_BYTE;
      end
      else if (wr_acc)
      begin
         if (hit_ctl)
            ctl_r <= wbyte & 8'hf3;
         if (hit_exp)
            exp_r <= wbyte & 8'h01;
         if (hit_baud)
            baud_r <= wbyte;
         if (hit_fine)
            fine_r <= wbyte[3:0];
         if (hit_clk)
            clk_ctl_r <= wbyte & 8'h3d;
         if (hit_mode)
            mode_r <= wbyte & 8'h1e;
      end

   // sticky flags and interrupt status; set wins over a same-cycle clear
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         flags_r  <= `RST_BYTE;
         irq_st_r <= `RST_BYTE;
      end
      else
      begin
         flags_r  <= uart_ctl_pkg::w1c(flags_r, flag_set, flag_clr);
         irq_st_r <= uart_ctl_pkg::w1c(irq_st_r, irq_set, irq_clr);
      end

   // transmit buffer; a new write beats a same-cycle take by the shifter
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         tx_buf_r <= `RST_BYTE;
         tx_buffer_empty_flag_r   <= `RST_TX_EMPTY;
      end
      else if (tx_write)
      begin
         tx_buf_r <= wbyte;
         tx_buffer_empty_flag_r   <= 1'b0;
      end
      else if (tx_taken)
         tx_buffer_empty_flag_r <= 1'b1;

   // receive buffer storage and level
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
      begin
         rx_mem_r[0] <= `RST_BYTE;
         rx_mem_r[1] <= `RST_BYTE;
         rx_cnt_r    <= 2'h0;
         full_lvl_r  <= 1'b0;
      end
      else
      begin
         if (rx_pop)
            rx_mem_r[0] <= rx_mem_r[1];
         if (rx_push && rx_slot == 2'h0)
            rx_mem_r[0] <= rx_byte;
         if (rx_push && rx_slot != 2'h0)
            rx_mem_r[1] <= rx_byte;
         rx_cnt_r   <= rx_cnt_nxt;
         full_lvl_r <= full_nxt;
      end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge core_clk or negedge rst_sync_b)
      if (!rst_sync_b)
         prdata_r <= 32'h0000_0000;
      else if (rd_setup)
         prdata_r <= {24'h00_0000, mapped ? rd_byte : 8'h00}; // misaligned reads zero too

   assign prdata = prdata_r;

   // interrupt: control bits 7..4 mask the matching status bits
   assign irq = |(irq_st_r[7:4] & ctl_r[7:4]);

   // configuration outputs
   assign port_enable   = ctl_r[`CTL_ENABLE];
   assign infrared_mode = exp_r[0];
   assign char_len_8    = mode_r[4];
   assign parity_en     = mode_r[3];
   assign parity_odd    = mode_r[2];
   assign stop_bits_2   = mode_r[1];

   // count clock and baud generator
   count_clock_gen u_count_clock_gen
   (
      .core_clk         (core_clk),
      .rst_sync_b       (rst_sync_b),
      .osc_pins         ({ext_clock, high_speed_oscillator, low_speed_oscillator,
                          internal_oscillator}),
      .clk_source       (clk_ctl_r[`CLK_SRC_MSB:`CLK_SRC_LSB]),
      .clk_divide       (clk_ctl_r[`CLK_DIV_MSB:`CLK_DIV_LSB]),
      .clk_gate         (clk_ctl_r[`CLK_GATE]),
      .run              (port_enable),
      .baud_divisor     (baud_r),
      .fine_delay_count (fine_r),
      .baud_tick        (baud_tick)
   );

   a_tx_done_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      tx_done_evt |=> irq_st_r[7] && (ctl_r[7] -> irq))
      else $error("transmission complete interrupt gating wrong");

   a_rx_err_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (rx_overrun || (rx_take && rx_frame_err)) |=> irq_st_r[6] && (ctl_r[6] -> irq))
      else $error("receive error interrupt not raised");

   a_rx_full_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (full_nxt && !full_lvl_r) |=> irq_st_r[5] && (ctl_r[5] -> irq))
      else $error("receive full interrupt not raised");

   a_tx_empty_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (tx_taken && !tx_write) |=> tx_buffer_empty_flag_r && irq_st_r[4] && (ctl_r[4] -> irq))
      else $error("transmit empty interrupt not raised");

   a_full_level: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      ##1 full_lvl_r == ($past(ctl_r[1]) ? (rx_cnt_r == 2'h2) : (rx_cnt_r != 2'h0)))
      else $error("full level disagrees with threshold");

   a_tx_done_flag: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      tx_done_evt |=> status_w[7] ##1 ($past(flag_clr[7]) || status_w[7]))
      else $error("transmission complete flag lost");

   a_second_byte: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      (rx_take && rx_cnt_r == 2'h1 && !rx_pop) |=> status_w[3] && status_w[1])
      else $error("second byte flag not raised");

   a_tx_empty_flag: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
      tx_write |=> !status_w[0] && tx_byte == $past(wbyte))
      else $error("transmit empty flag not cleared on write");

endmodule : uart_control_baud_clock

// ---- tb/shift_partner.sv ----
`timescale 1ns/1ps

module shift_partner
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // transmit side
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_byte_valid,
   output logic            tx_byte_ready,
   output logic            tx_busy,
   output logic            tx_done_evt,
   // receive side
   output logic [7:0]      rx_byte,
   output logic            rx_byte_valid,
   output logic            rx_frame_err,
   output logic            rx_parity_err,
   // cycles to stall before a byte is taken
   input  wire logic [4:0] stall
);
   logic [7:0] last_tx;
   int         done_cnt;

   // take a byte after the stall, shift it a few cycles, then pulse done
   initial
   begin
      tx_byte_ready = 1'b0;
      tx_busy = 1'b0;
      tx_done_evt = 1'b0;
      rx_byte = 8'h00;
      rx_byte_valid = 1'b0;
      rx_frame_err = 1'b0;
      rx_parity_err = 1'b0;
      done_cnt = 0;
      forever
      begin
         @(posedge core_clk);
         if (rst_b === 1'b1 && tx_byte_valid === 1'b1)
         begin
            repeat (stall) @(posedge core_clk);
            tx_byte_ready <= 1'b1;
            @(posedge core_clk);
            last_tx = tx_byte;
            tx_byte_ready <= 1'b0;
            tx_busy <= 1'b1;
            repeat (4) @(posedge core_clk);
            tx_busy <= 1'b0;
            tx_done_evt <= 1'b1;
            @(posedge core_clk);
            tx_done_evt <= 1'b0;
            done_cnt++;
         end
      end
   end

   // one received byte; the data line shows the inverse once valid drops
   task automatic send_rx(input logic [7:0] b, input logic fe, input logic pe);
      @(posedge core_clk);
      rx_byte <= b;
      rx_byte_valid <= 1'b1;
      rx_frame_err <= fe;
      rx_parity_err <= pe;
      @(posedge core_clk);
      rx_byte <= ~b;
      rx_byte_valid <= 1'b0;
      rx_frame_err <= 1'b0;
      rx_parity_err <= 1'b0;
   endtask : send_rx

endmodule : shift_partner

// ---- tb/tb_uart_control_baud_clock.sv ----
`timescale 1ns/1ps
`include "uart_ctl_regs.svh"

module tb_uart_control_baud_clock;
   logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [16:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  tx_byte, rx_byte, rd;
   logic        tx_byte_valid, tx_byte_ready, tx_busy, tx_done_evt, rx_byte_valid;
   logic        rx_frame_err, rx_parity_err, port_enable, infrared_mode, baud_tick;
   logic [3:0]  osc = 4'h0;
   logic [3:0]  md;
   logic [4:0]  stall = 5'h00;
   int          error_cnt = 0, n_compared = 0, cyc = 0, t, tb, k, n;
   int          per [4] = '{4, 6, 8, 10};
   int          ckf [8] = '{8, 32, 6, 6, 8, 32, 10, 10};
   logic [7:0]  ck [8] = '{8'h11, 8'h31, 8'h05, 8'h15, 8'h09, 8'h29, 8'h0d, 8'h3d};
   logic [14:0] ri [6] = '{`IDX_CONTROL, `IDX_EXPANSION, `IDX_BAUD, `IDX_FINE, `IDX_CLOCK_CTL,
                           `IDX_MODE};
   logic [7:0]  rm [6] = '{8'hf3, 8'h01, 8'hff, 8'h0f, 8'h3d, 8'h1e};

   uart_control_baud_clock dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .internal_oscillator(osc[0]),
      .low_speed_oscillator(osc[1]), .high_speed_oscillator(osc[2]), .ext_clock(osc[3]),
      .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
      .tx_busy(tx_busy), .tx_done_evt(tx_done_evt), .rx_byte(rx_byte),
      .rx_byte_valid(rx_byte_valid), .rx_frame_err(rx_frame_err),
      .rx_parity_err(rx_parity_err), .port_enable(port_enable), .infrared_mode(infrared_mode),
      .char_len_8(md[3]), .parity_en(md[2]), .parity_odd(md[1]), .stop_bits_2(md[0]),
      .baud_tick(baud_tick), .irq(irq));

   shift_partner partner (.core_clk(core_clk), .rst_b(rst_b), .tx_byte(tx_byte),
      .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_busy(tx_busy),
      .tx_done_evt(tx_done_evt), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
      .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err), .stall(stall));

   // 200 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // oscillators with distinct periods so a wrong source shows as a wrong ratio
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++)
         if (cyc % (per[i] / 2) == 0)
            osc[i] <= ~osc[i];
      if (cyc == 60000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // one apb transfer; waits for pready, takes read data and error at that edge
   task automatic apb(input logic w, input logic [14:0] i, input logic [7:0] d);
      int m;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      m = 0;
      do
      begin
         @(posedge core_clk);
         m++;
      end
      while (pready !== 1'b1 && m < 40);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", m < 40, 1'b1);
      // register outputs settle after the access edge; look at them half a cycle later
      @(negedge core_clk);
   endtask : apb

   task automatic wr(input logic [14:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask : wr

   task automatic rc(input string nm, input logic [14:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      check(nm, rd, e);
   endtask : rc

   // cycles spanned by 16 baud ticks, after two ticks let the new setting settle
   task automatic span(output int s);
      n = 0;
      s = 0;
      while (n < 18 && s < 20000)
      begin
         @(posedge core_clk);
         if (n >= 2)
            s++;
         if (baud_tick === 1'b1)
            n++;
      end
   endtask : span

   // main sequence
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 17'h0_0000;
      pwdata = 32'h0000_0000;
      rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc("status reset", `IDX_STATUS, 8'h01);
      for (k = 0; k < 6; k++)
      begin
         rc("reg reset", ri[k], 8'h00);
         wr(ri[k], 8'hff);
         rc("reg ones", ri[k], rm[k]);
         if (k == 5)
            check("mode pins", md, 4'hf);
         wr(ri[k], 8'h00);
      end
      wr(`IDX_EXPANSION, 8'h01);
      check("infrared", infrared_mode, 1'b1);
      apb(1'b0, 15'h4109, 8'h00);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 8'h00);
      wr(`IDX_CONTROL, 8'h01);
      check("port enable", port_enable, 1'b1);
      // transmit, prompt then stalled partner
      for (k = 0; k < 2; k++)
      begin
         stall <= k ? 5'h0c : 5'h00;
         wr(`IDX_TX_DATA, 8'h5a + 8'(k));
         if (k)
            rc("tx pending", `IDX_STATUS, 8'h00);
         t = 0;
         while (partner.done_cnt < k + 1 && t < 300)
         begin
            @(posedge core_clk);
            t++;
         end
         check("tx byte", partner.last_tx, 8'h5a + 8'(k));
         rc("tx done status", `IDX_STATUS, 8'h81);
         rc("tx irq flags", `IDX_IRQ_STATUS, 8'h90);
         check("irq masked", irq, 1'b0);
         wr(`IDX_CONTROL, 8'h81);
         check("irq done", irq, 1'b1);
         wr(`IDX_IRQ_STATUS, 8'h80);
         wr(`IDX_STATUS, 8'h80);
         check("irq done clr", irq, 1'b0);
         rc("done cleared", `IDX_STATUS, 8'h01);
         wr(`IDX_CONTROL, 8'h11);
         check("irq empty", irq, 1'b1);
         wr(`IDX_IRQ_STATUS, 8'h10);
         check("irq empty clr", irq, 1'b0);
         wr(`IDX_CONTROL, 8'h01);
      end
      // receive with one and two byte thresholds
      wr(`IDX_CONTROL, 8'h21);
      partner.send_rx(8'h3c, 1'b0, 1'b0);
      rc("rx one status", `IDX_STATUS, 8'h03);
      rc("rx one flag", `IDX_IRQ_STATUS, 8'h20);
      check("irq full", irq, 1'b1);
      rc("rx data", `IDX_RX_DATA, 8'h3c);
      wr(`IDX_IRQ_STATUS, 8'h20);
      wr(`IDX_CONTROL, 8'h23);
      partner.send_rx(8'h11, 1'b0, 1'b0);
      rc("rx half", `IDX_IRQ_STATUS, 8'h00);
      partner.send_rx(8'h22, 1'b0, 1'b0);
      rc("rx two status", `IDX_STATUS, 8'h0b);
      rc("rx two flag", `IDX_IRQ_STATUS, 8'h20);
      rc("rx first", `IDX_RX_DATA, 8'h11);
      rc("rx second", `IDX_RX_DATA, 8'h22);
      wr(`IDX_IRQ_STATUS, 8'h20);
      // frame then parity error
      for (k = 0; k < 2; k++)
      begin
         wr(`IDX_CONTROL, 8'h41);
         partner.send_rx(8'h77, k == 0, k == 1);
         rc("rx err flag", `IDX_IRQ_STATUS, 8'h60);
         check("irq err", irq, 1'b1);
         wr(`IDX_CONTROL, 8'h01);
         check("irq err blocked", irq, 1'b0);
         apb(1'b0, `IDX_STATUS, 8'h00);
         check("err status", rd & 8'h60, k ? 8'h20 : 8'h40);
         wr(`IDX_STATUS, 8'h60);
         wr(`IDX_IRQ_STATUS, 8'h60);
         apb(1'b0, `IDX_RX_DATA, 8'h00);
      end
      // baud ticks: sources, divide codes, fine delay, gate
      wr(`IDX_BAUD, 8'h03);
      wr(`IDX_CLOCK_CTL, 8'h01);
      span(tb);
      for (k = 0; k < 8; k++)
      begin
         wr(`IDX_CLOCK_CTL, ck[k]);
         span(t);
         check("clock ratio", t * 4, tb * ckf[k]);
      end
      wr(`IDX_CLOCK_CTL, 8'h01);
      wr(`IDX_FINE, 8'h0f);
      span(t);
      check("fine delay", t, tb + 60);
      wr(`IDX_CLOCK_CTL, 8'h00);
      repeat (20) @(posedge core_clk);
      n = 0;
      repeat (300)
      begin
         @(posedge core_clk);
         if (baud_tick !== 1'b0)
            n++;
      end
      check("gated ticks", n, 0);
      conclude();
   end

endmodule : tb_uart_control_baud_clock
